/* verilog/pwp_pkg.sv */
// package: register map, reset values and state type of the write protection bank
`default_nettype none
package pwp_pkg;
	// byte offsets of the four registers (low four address bits)
	localparam logic [3:0]  G2_CLR_OFS     = 4'h0;
	localparam logic [3:0]  G2_SET_OFS     = 4'h4;
	localparam logic [3:0]  G1_CLR_OFS     = 4'h8;
	localparam logic [3:0]  G1_SET_OFS     = 4'hC;
	// values after reset
	localparam logic [31:0] G2_RESET       = 32'h0080_0000;
	localparam logic [31:0] G1_RESET       = 32'h0000_0002;
	// bits that software may change; all other bits hold their reset value
	localparam logic [31:0] G2_WR_MASK     = 32'h001F_07FE;
	localparam logic [31:0] G1_WR_MASK     = 32'h0000_006E;
	// position of the first control timer unit bit in group two
	localparam int          TIMER_LSB      = 8;
	localparam int          TIMER_COUNT    = 3;
	// whole state of the bank
	typedef struct packed {
		logic [31:0] g1;
		logic [31:0] g2;
		logic        ack;
		logic [31:0] rdat;
	} pwp_state_type;
endpackage : pwp_pkg
`default_nettype wire

/* verilog/pwp_bank.sv */
// module: peripheral write protection bank with a classic wishbone slave
`default_nettype none
module pwp_bank (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [3:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// protection state toward the guarded peripherals
	output logic      [31:0] protection_group_one_o,
	output logic      [31:0] protection_group_two_o,
	output logic      [2:0]  control_timer_units_protect_o
);

	pwp_pkg::pwp_state_type state_q;
	pwp_pkg::pwp_state_type state_d;
	logic                   req;
	logic                   wr_g2_clr;
	logic                   wr_g2_set;
	logic                   wr_g1_clr;
	logic                   wr_g1_set;
	logic [31:0]            wmask;

	// expand byte selects into a bit mask
	function automatic logic [31:0] lane_mask(input logic [3:0] sel);
		lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction : lane_mask

	// set or clear the written ones; written zeros and fixed bits stay
	function automatic logic [31:0] apply(input logic [31:0] cur, input logic [31:0] wm,
			input logic set, input logic [31:0] msk);
		if (set) begin
			apply = cur | (wm & msk);
		end else begin
			apply = cur & ~(wm & msk);
		end
	endfunction : apply

	// read value of a register address; clear and set alias the same state
	function automatic logic [31:0] read_val(input logic [3:0] adr,
			input logic [31:0] g1, input logic [31:0] g2);
		if (adr == pwp_pkg::G2_CLR_OFS || adr == pwp_pkg::G2_SET_OFS) begin
			read_val = g2;
		end else if (adr == pwp_pkg::G1_CLR_OFS || adr == pwp_pkg::G1_SET_OFS) begin
			read_val = g1;
		end else begin
			read_val = 32'h0000_0000; // unmapped reads zero
		end
	endfunction : read_val

	// decode of the write that takes effect at the acknowledging edge
	assign req       = cyc_i & stb_i;
	assign wmask     = dat_i & lane_mask(sel_i);
	assign wr_g2_clr = req & we_i & state_q.ack & (adr_i == pwp_pkg::G2_CLR_OFS);
	assign wr_g2_set = req & we_i & state_q.ack & (adr_i == pwp_pkg::G2_SET_OFS);
	assign wr_g1_clr = req & we_i & state_q.ack & (adr_i == pwp_pkg::G1_CLR_OFS);
	assign wr_g1_set = req & we_i & state_q.ack & (adr_i == pwp_pkg::G1_SET_OFS);

	// next state
	always_comb begin
		state_d     = state_q;
		state_d.ack = req & ~state_q.ack;
		if (req & ~state_q.ack) begin
			state_d.rdat = read_val(adr_i, state_q.g1, state_q.g2);
		end
		if (wr_g2_clr | wr_g2_set) begin
			state_d.g2 = apply(state_q.g2, wmask, wr_g2_set, pwp_pkg::G2_WR_MASK);
		end
		if (wr_g1_clr | wr_g1_set) begin
			state_d.g1 = apply(state_q.g1, wmask, wr_g1_set, pwp_pkg::G1_WR_MASK);
		end
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q.g1   <= pwp_pkg::G1_RESET;
			state_q.g2   <= pwp_pkg::G2_RESET;
			state_q.ack  <= 1'b0;
			state_q.rdat <= 32'h0000_0000;
		end else begin
			state_q <= state_d;
		end
	end

	// outputs straight from the state flops
	assign dat_o                         = state_q.rdat;
	assign ack_o                         = state_q.ack;
	assign protection_group_one_o        = state_q.g1;
	assign protection_group_two_o        = state_q.g2;
	assign control_timer_units_protect_o =
		state_q.g2[pwp_pkg::TIMER_LSB +: pwp_pkg::TIMER_COUNT];

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// a read request followed by its acknowledge
	sequence g2_read_s;
		req && !we_i && !ack_o && (adr_i == pwp_pkg::G2_CLR_OFS || adr_i == pwp_pkg::G2_SET_OFS)
		##1 ack_o;
	endsequence

	zero_write_kept_a: assert property ((wr_g2_clr || wr_g2_set) |=>
		((protection_group_two_o ^ $past(protection_group_two_o)) & ~$past(wmask)) == 32'h0000_0000)
		else $error("zero write changed a protection bit");

	clear_removes_a: assert property (wr_g2_clr |=>
		(protection_group_two_o & $past(wmask) & pwp_pkg::G2_WR_MASK) == 32'h0000_0000)
		else $error("clear write left a protection bit set");

	set_protects_a: assert property (wr_g2_set |=>
		(protection_group_two_o & $past(wmask) & pwp_pkg::G2_WR_MASK)
		== ($past(wmask) & pwp_pkg::G2_WR_MASK))
		else $error("set write did not protect");

	readback_state_a: assert property (g2_read_s |-> dat_o == protection_group_two_o)
		else $error("read value differs from protection state");

	timer_bits_a: assert property (g2_read_s |-> dat_o[10:8] == control_timer_units_protect_o)
		else $error("timer bits not at positions 8 to 10");

	// helpers for the checks below
	logic adr_mapped; // request hits one of the four registers
	logic wr_any;     // some write lands at this edge
	assign adr_mapped = (adr_i == pwp_pkg::G2_CLR_OFS) || (adr_i == pwp_pkg::G2_SET_OFS) ||
		(adr_i == pwp_pkg::G1_CLR_OFS) || (adr_i == pwp_pkg::G1_SET_OFS);
	assign wr_any     = wr_g2_clr | wr_g2_set | wr_g1_clr | wr_g1_set;

	// a request taken at this edge, acknowledged at the next
	sequence taken_s;
		req && !ack_o ##1 ack_o;
	endsequence

	// a group one read and its acknowledge
	sequence g1_read_s;
		req && !we_i && !ack_o && (adr_i == pwp_pkg::G1_CLR_OFS || adr_i == pwp_pkg::G1_SET_OFS)
		##1 ack_o;
	endsequence

	// a read of an unmapped address and its acknowledge
	sequence other_read_s;
		req && !we_i && !ack_o && !adr_mapped
		##1 ack_o;
	endsequence

	// a write to an unmapped address at its acknowledging edge
	sequence other_write_s;
		req && we_i && ack_o && !adr_mapped;
	endsequence

	// a read of any address at its acknowledging edge
	sequence read_done_s;
		req && !we_i && ack_o;
	endsequence

	// every taken request is answered exactly one cycle later
	request_acked_a: assert property (
		(req && !ack_o) |-> taken_s)
		else $error("request not acknowledged after one cycle");

	// the acknowledge is a single-cycle pulse, so one request never answers twice
	ack_single_a: assert property (
		ack_o |=> !ack_o)
		else $error("acknowledge held for more than one cycle");

	// no acknowledge without a request standing in the cycle before
	ack_needs_req_a: assert property (
		ack_o |-> $past(req))
		else $error("acknowledge without a request");

	// an idle bus is never acknowledged
	idle_no_ack_a: assert property (
		!req |=> !ack_o)
		else $error("acknowledge after an idle cycle");

	// read data only moves when a new request is taken
	read_data_held_a: assert property (
		!(req && !ack_o) |=> $stable(dat_o))
		else $error("read data changed without a request");

	// a group one read returns the live protection state
	// whichever of its two addresses is used
	g1_readback_a: assert property (
		g1_read_s |-> dat_o == protection_group_one_o)
		else $error("group one read differs from protection state");

	// unmapped addresses read as zero
	unmapped_read_zero_a: assert property (
		other_read_s |-> dat_o == 32'h0000_0000)
		else $error("unmapped read returned nonzero data");

	// a write to an unmapped address changes no protection bit
	// a stray pointer must never unlock a peripheral
	unmapped_write_kept_a: assert property (
		other_write_s |=> $stable(protection_group_one_o) && $stable(protection_group_two_o))
		else $error("unmapped write changed protection state");

	// reads never disturb the protection state
	read_keeps_state_a: assert property (
		read_done_s |=> $stable(protection_group_one_o) && $stable(protection_group_two_o))
		else $error("read changed protection state");

	// at most one register is written at any edge
	one_write_strobe_a: assert property (
		$onehot0({wr_g2_clr, wr_g2_set, wr_g1_clr, wr_g1_set}))
		else $error("two register writes at one edge");

	// without a landing write both groups hold their state
	// protection may only move under software control
	idle_state_kept_a: assert property (
		!wr_any |=> $stable(protection_group_one_o) && $stable(protection_group_two_o))
		else $error("protection state changed without a write");

	// zeros written to group one leave those bits alone
	g1_zero_kept_a: assert property ((wr_g1_clr || wr_g1_set) |=>
		((protection_group_one_o ^ $past(protection_group_one_o)) & ~$past(wmask)) == 32'h0000_0000)
		else $error("zero write changed a group one bit");

	// ones written to the group one clear register unprotect
	g1_clear_removes_a: assert property (wr_g1_clr |=>
		(protection_group_one_o & $past(wmask) & pwp_pkg::G1_WR_MASK) == 32'h0000_0000)
		else $error("clear write left a group one bit set");

	// ones written to the group one set register protect
	g1_set_protects_a: assert property (wr_g1_set |=>
		(protection_group_one_o & $past(wmask) & pwp_pkg::G1_WR_MASK)
		== ($past(wmask) & pwp_pkg::G1_WR_MASK))
		else $error("set write did not protect a group one bit");

	// a clear write never protects a group two bit that was open
	g2_clear_only_a: assert property (wr_g2_clr |=>
		(protection_group_two_o & ~$past(protection_group_two_o)) == 32'h0000_0000)
		else $error("clear write protected a group two bit");

	// a set write never unprotects a group two bit
	g2_set_only_a: assert property (wr_g2_set |=>
		($past(protection_group_two_o) & ~protection_group_two_o) == 32'h0000_0000)
		else $error("set write unprotected a group two bit");

	// a clear write never protects a group one bit that was open
	g1_clear_only_a: assert property (wr_g1_clr |=>
		(protection_group_one_o & ~$past(protection_group_one_o)) == 32'h0000_0000)
		else $error("clear write protected a group one bit");

	// a set write never unprotects a group one bit
	g1_set_only_a: assert property (wr_g1_set |=>
		($past(protection_group_one_o) & ~protection_group_one_o) == 32'h0000_0000)
		else $error("set write unprotected a group one bit");

	// bytes outside the selected lanes keep their group two bits
	// so a narrow store cannot touch a neighbouring peripheral
	g2_lanes_kept_a: assert property ((wr_g2_clr || wr_g2_set) |=>
		((protection_group_two_o ^ $past(protection_group_two_o))
		& ~lane_mask($past(sel_i))) == 32'h0000_0000)
		else $error("unselected lane changed a group two bit");

	// bytes outside the selected lanes keep their group one bits
	// the same guard for the first group
	g1_lanes_kept_a: assert property ((wr_g1_clr || wr_g1_set) |=>
		((protection_group_one_o ^ $past(protection_group_one_o))
		& ~lane_mask($past(sel_i))) == 32'h0000_0000)
		else $error("unselected lane changed a group one bit");

	// group two bits outside the writable mask keep their reset value
	g2_fixed_bits_a: assert property (
		((protection_group_two_o ^ pwp_pkg::G2_RESET) & ~pwp_pkg::G2_WR_MASK) == 32'h0000_0000)
		else $error("fixed group two bit changed");

	// group one bits outside the writable mask keep their reset value
	g1_fixed_bits_a: assert property (
		((protection_group_one_o ^ pwp_pkg::G1_RESET) & ~pwp_pkg::G1_WR_MASK) == 32'h0000_0000)
		else $error("fixed group one bit changed");

	// a set of the first timer bit protects the first control timer unit
	timer_set_a: assert property (
		(wr_g2_set && wmask[pwp_pkg::TIMER_LSB]) |=> control_timer_units_protect_o[0])
		else $error("timer unit zero not protected by its set bit");

	// a clear of the second timer bit unprotects the second control timer unit
	timer_clear_a: assert property (
		(wr_g2_clr && wmask[pwp_pkg::TIMER_LSB + 1]) |=> !control_timer_units_protect_o[1])
		else $error("timer unit one still protected after its clear");

	// reset brings both groups back to their start state
	// checked through reset itself, so the default disable is switched off
	reset_values_a: assert property (disable iff (1'b0)
		rst_i |=> protection_group_one_o == pwp_pkg::G1_RESET
		&& protection_group_two_o == pwp_pkg::G2_RESET && !ack_o)
		else $error("state after reset differs from reset values");

endmodule : pwp_bank
`default_nettype wire

/* bench/pwp_wb_master.sv */
// wishbone master model for software
`default_nettype none
module pwp_wb_master (input wire logic clk_i, ack_i, input wire logic [31:0] dat_i,
	output logic cyc_o, stb_o, we_o, output logic [3:0] adr_o, sel_o, output logic [31:0] dat_o);
	timeunit 1ns / 1ns;
	initial {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
	task automatic xfer(input logic w, logic [3:0] a, logic [3:0] s, logic [31:0] d,
			output logic [31:0] r);
		@(posedge clk_i);
		{cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, s, d};
		do @(posedge clk_i); while (ack_i !== 1'b1);
		r = dat_i;
		{cyc_o, stb_o, dat_o} <= {2'b00, ~d};
	endtask : xfer
endmodule : pwp_wb_master
`default_nettype wire

/* bench/testbench.sv */
// protect bank bench
`default_nettype none
module testbench;
	timeunit 1ns / 1ns;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc, stb, we, ack;
	logic [3:0] adr, sel, lane = 4'hF;
	logic [2:0] tmr;
	logic [31:0] wd, rdat, g1, g2, e [2] = '{32'h0080_0000, 32'h0000_0002};
	int n_fail = 0, n_tests = 0, cyc_n = 0;
	always #20 clk_i = ~clk_i;
	always @(posedge clk_i) if (++cyc_n == 1000) final_report(1'b1);
	pwp_bank pwp_bank_inst (.clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
		.sel_i(sel), .dat_i(wd), .dat_o(rdat), .ack_o(ack), .protection_group_one_o(g1),
		.protection_group_two_o(g2), .control_timer_units_protect_o(tmr));
	pwp_wb_master pwp_wb_master_inst (.clk_i, .ack_i(ack), .dat_i(rdat), .cyc_o(cyc),
		.stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wd));
	task automatic cmp(input logic [31:0] got, exp);
		n_tests++;
		if (got !== exp) n_fail++;
		if (got !== exp) $display("ERROR %0t %h %h", $time, got, exp);
	endtask : cmp
	// one bus transfer, then outputs against model
	task automatic op(input logic w, logic [3:0] a, logic [31:0] d);
		logic [31:0] r, m;
		m = d & {{8{lane[3]}}, {8{lane[2]}}, {8{lane[1]}}, {8{lane[0]}}}
			& (a[3] ? 32'h0000_006E : 32'h001F_07FE);
		pwp_wb_master_inst.xfer(w, a, lane, d, r);
		if (w && a[1:0] == 2'b00) e[a[3]] = a[2] ? e[a[3]] | m : e[a[3]] & ~m;
		if (!w) cmp(r, a[1:0] == 2'b00 ? e[a[3]] : 32'h0000_0000);
		@(negedge clk_i);
		cmp(g1, e[1]);
		cmp(g2, e[0]);
		cmp({29'h0, tmr}, {29'h0, e[0][10:8]});
	endtask : op
	task automatic t_group2;
		for (int i = 0; i < 16; i += 2) op(1'b0, i[3:0], 32'h0000_0000);
		op(1'b1, 4'h4, 32'h0000_0100);
		op(1'b1, 4'h4, 32'h0000_0600);
		op(1'b1, 4'h0, 32'hFFFF_F8FF);
		op(1'b1, 4'h0, 32'h0000_0200);
		$display("group two test done");
	endtask : t_group2
	task automatic t_group1;
		op(1'b1, 4'hC, 32'hFFFF_FFFF);
		op(1'b1, 4'h8, 32'hFFFF_FFFD);
		op(1'b0, 4'hC, 32'h0000_0000);
		op(1'b1, 4'h2, 32'hFFFF_FFFF);
		$display("group one test done");
	endtask : t_group1
	// narrow stores: only selected byte lanes act
	task automatic t_lanes;
		lane = 4'b0010;
		op(1'b1, 4'h4, 32'hFFFF_FFFF);
		lane = 4'b1101;
		op(1'b1, 4'h0, 32'hFFFF_FFFF);
		lane = 4'hF;
		$display("lane test done");
	endtask : t_lanes
	// reset in mid run restores the start state
	task automatic t_reset;
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		e = '{32'h0080_0000, 32'h0000_0002};
		@(negedge clk_i);
		cmp(g1, e[1]);
		cmp(g2, e[0]);
		cmp({31'h0, ack}, 32'h0000_0000);
		$display("reset test done");
	endtask : t_reset
	task automatic final_report(input bit to);
		n_fail += to;
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : final_report
	// reset, then tests
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		t_group2();
		t_lanes();
		t_group1();
		t_reset();
		t_group2();
		final_report(1'b0);
	end
endmodule : testbench
`default_nettype wire
